// file: verilog/clock_gate_pkg.sv
// Package for the peripheral clock gating block: register offsets, masks,
// reset values, field positions and the register select enumeration.
// Assumes a 32-bit AHB-Lite register port and one system clock domain.
package clock_gate_pkg;

  // Byte offsets of the three gating registers
  localparam logic [7:0]  HS_GATE_OFFSET = 8'h14;         // high_speed_bus_clock_gate
  localparam logic [7:0]  P2_GATE_OFFSET = 8'h18;         // periph_bus2_clock_gate
  localparam logic [7:0]  P1_GATE_OFFSET = 8'h1C;         // periph_bus1_clock_gate

  // Writable bits; everything else reads zero
  localparam logic [31:0] HS_GATE_MASK   = 32'h0002_1005;
  localparam logic [31:0] P2_GATE_MASK   = 32'h0000_5A1D;
  localparam logic [31:0] P1_GATE_MASK   = 32'h102E_0803;

  // Reset values
  localparam logic [31:0] HS_GATE_RESET  = 32'h0002_1004;
  localparam logic [31:0] P2_GATE_RESET  = 32'h0000_0000;
  localparam logic [31:0] P1_GATE_RESET  = 32'h0000_0000;

  // High-speed bus field positions
  localparam int POWER_DELIVERY_CLOCK_ON = 17;
  localparam int FULLSPEED_USB_CLOCK_ON  = 12;
  localparam int SRAM_SLEEP_CLOCK_ON     = 2;
  localparam int DMA_CLOCK_ON            = 0;

  // Second peripheral bus field positions
  localparam int SERIAL1_CLOCK_ON        = 14;
  localparam int SPI_CLOCK_ON            = 12;
  localparam int ADVANCED_TIMER_CLOCK_ON = 11;
  localparam int ADC_CLOCK_ON            = 9;
  localparam int PORT_C_CLOCK_ON         = 4;
  localparam int PORT_B_CLOCK_ON         = 3;
  localparam int PORT_A_CLOCK_ON         = 2;
  localparam int ALT_FUNCTION_CLOCK_ON   = 0;

  // First peripheral bus field positions
  localparam int POWER_IF_CLOCK_ON       = 28;
  localparam int I2C_CLOCK_ON            = 21;
  localparam int SERIAL4_CLOCK_ON        = 19;
  localparam int SERIAL3_CLOCK_ON        = 18;
  localparam int SERIAL2_CLOCK_ON        = 17;
  localparam int WINDOW_WATCHDOG_CLOCK_ON = 11;
  localparam int TIMER3_CLOCK_ON         = 1;
  localparam int TIMER2_CLOCK_ON         = 0;

  // Number of gated clocks
  localparam int GATE_COUNT              = 20;

  // Bus encodings
  localparam logic [2:0]  HSIZE_WORD     = 3'h2;
  localparam logic        HRESP_OKAY     = 1'h0;

  // Register selected by a bus access
  typedef enum logic [1:0]
  {
    SEL_NONE = 2'b00,
    SEL_HS   = 2'b01,
    SEL_P2   = 2'b10,
    SEL_P1   = 2'b11
  } reg_sel_t;

endpackage : clock_gate_pkg

// file: verilog/gclk_cell.sv
// One gated clock: a half-rate clock that only ever stops low.
// Assumes enable comes from logic on the same clock.
`timescale 1ns/1ns
module gclk_cell
  import clock_gate_pkg::*;
(
  input  wire logic clock,
  input  wire logic srst,
  input  wire logic enable,
  output logic      gclk
);

  // Whole state
  typedef struct packed
  {
    logic gclk_r;                                         // Gated clock level
  } cell_state_t;

  cell_state_t st_r;
  cell_state_t st_nxt;

  // High phase always completes; low phase holds while disabled
  always_comb
  begin
    st_nxt        = st_r;
    st_nxt.gclk_r = st_r.gclk_r ? 1'b0 : enable;
  end

  // State register
  always_ff @(posedge clock)
  begin
    if (srst)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign gclk = st_r.gclk_r;

  AST_GCLK_STOPS: assert property (@(posedge clock) disable iff (srst)
    !enable |=> !gclk)
    else $error("gated clock ran while disabled");

  // The edge that still sees reset sampled high holds the cell low, so it is no start
  AST_GCLK_RUNS: assert property (@(posedge clock) disable iff (srst)
    (enable && !srst) |=> (gclk != $past(gclk)))
    else $error("gated clock stalled while enabled");

  AST_GCLK_WHOLE: assert property (@(posedge clock) disable iff (srst)
    $rose(gclk) |=> !gclk ##1 (!gclk || $past(enable)))
    else $error("gated clock pulse truncated or stretched");

endmodule : gclk_cell

// file: verilog/ahb_reg_port.sv
// AHB-Lite slave front end: decodes the address phase and holds the
// write select for the data phase. Zero wait states, always OKAY.
// Assumes word transfers; hready is this slave's own hreadyout.
`timescale 1ns/1ns
module ahb_reg_port
  import clock_gate_pkg::*;
#(
  parameter int ADDR_W = 8                                // Decoded address bits
)
(
  input  wire logic        clock,
  input  wire logic        srst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output reg_sel_t         rd_sel,
  output logic             rd_req,
  output reg_sel_t         wr_sel
);

  // Offsets must fit in the decoded bits
  if (ADDR_W < 8 || ADDR_W > 32)
    $error("ADDR_W must be 8 to 32");

  // Whole state
  typedef struct packed
  {
    reg_sel_t wr_sel_r;                                   // Write pending in data phase
    logic     hready_r;                                   // Ready answer
    logic     hresp_r;                                    // Response, always OKAY
  } port_state_t;

  port_state_t st_r;
  port_state_t st_nxt;
  reg_sel_t    addr_sel;
  logic        addr_phase;

  // Decode of the address phase; unmapped gives SEL_NONE
  always_comb
  begin
    addr_phase = hsel && htrans[1] && hready && (hsize == HSIZE_WORD);
    addr_sel   = SEL_NONE;
    if (haddr[ADDR_W-1:0] == ADDR_W'(HS_GATE_OFFSET))
      addr_sel = SEL_HS;
    else if (haddr[ADDR_W-1:0] == ADDR_W'(P2_GATE_OFFSET))
      addr_sel = SEL_P2;
    else if (haddr[ADDR_W-1:0] == ADDR_W'(P1_GATE_OFFSET))
      addr_sel = SEL_P1;
    st_nxt          = st_r;
    st_nxt.hready_r = 1'b1;
    st_nxt.hresp_r  = HRESP_OKAY;
    st_nxt.wr_sel_r = (addr_phase && hwrite) ? addr_sel : SEL_NONE;
  end

  // State register
  always_ff @(posedge clock)
  begin
    if (srst)
      st_r <= '{wr_sel_r: SEL_NONE, hready_r: 1'b1, hresp_r: HRESP_OKAY};
    else
      st_r <= st_nxt;
  end

  assign hreadyout = st_r.hready_r;
  assign hresp     = st_r.hresp_r;
  assign wr_sel    = st_r.wr_sel_r;
  assign rd_req    = addr_phase && !hwrite;
  assign rd_sel    = addr_sel;

  AST_ZERO_WAIT: assert property (@(posedge clock) disable iff (srst)
    hreadyout && (hresp == HRESP_OKAY))
    else $error("slave inserted a wait state or error");

endmodule : ahb_reg_port

// file: verilog/periph_clock_gate.sv
// Peripheral clock gating: three gating registers on AHB-Lite and
// twenty half-rate gated clocks, each stopping only in its low phase.
// Assumes one system clock, a synchronous high reset and a sleep_mode
// level driven by logic on the same clock.
//
// Local design decision: the AHB-Lite slave port.
`timescale 1ns/1ns

module periph_clock_gate
  import clock_gate_pkg::*;
#(
  parameter int ADDR_W = 8                                // Decoded address bits
)
(
  input  wire logic        clock,
  input  wire logic        srst,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // System sleep state
  input  wire logic        sleep_mode,
  // Gated clocks, high-speed bus
  output logic             power_delivery_gclk,
  output logic             fullspeed_usb_gclk,
  output logic             sram_gclk,
  output logic             dma_gclk,
  // Gated clocks, second peripheral bus
  output logic             serial1_gclk,
  output logic             spi_gclk,
  output logic             advanced_timer_gclk,
  output logic             adc_gclk,
  output logic             port_c_gclk,
  output logic             port_b_gclk,
  output logic             port_a_gclk,
  output logic             alt_function_gclk,
  // Gated clocks, first peripheral bus
  output logic             power_if_gclk,
  output logic             i2c_gclk,
  output logic             serial4_gclk,
  output logic             serial3_gclk,
  output logic             serial2_gclk,
  output logic             window_watchdog_gclk,
  output logic             timer3_gclk,
  output logic             timer2_gclk
);

  // Whole state of the block
  typedef struct packed
  {
    logic [31:0] hs_gate_r;                               // high_speed_bus_clock_gate
    logic [31:0] p2_gate_r;                               // periph_bus2_clock_gate
    logic [31:0] p1_gate_r;                               // periph_bus1_clock_gate
    logic [31:0] hrdata_r;                                // Read data of the data phase
  } gate_state_t;

  gate_state_t st_r;
  gate_state_t st_nxt;

  // Bus front-end results
  reg_sel_t    rd_sel;                                    // Register read in this address phase
  logic        rd_req;                                    // Read address phase taken
  reg_sel_t    wr_sel;                                    // Register written in this data phase

  // Per-clock enables and gated clocks, index order below
  logic [GATE_COUNT-1:0] gate_en;
  logic [GATE_COUNT-1:0] gclk_vec;

  // Address phase decode and ready/response
  ahb_reg_port #(
    .ADDR_W    (ADDR_W)
  ) u_port (
    .clock     (clock),
    .srst      (srst),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hready    (hready),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .rd_sel    (rd_sel),
    .rd_req    (rd_req),
    .wr_sel    (wr_sel)
  );

  // Register update and read data
  // Reading from the next-state copy forwards a write in its data phase
  // to a read address phase in the same cycle, so back-to-back write then
  // read of one register returns the new value.
  always_comb
  begin
    st_nxt = st_r;
    // Data phase write; masking keeps reserved bits at zero
    case (wr_sel)
      SEL_HS:
        st_nxt.hs_gate_r = hwdata & HS_GATE_MASK;
      SEL_P2:
        st_nxt.p2_gate_r = hwdata & P2_GATE_MASK;
      SEL_P1:
        st_nxt.p1_gate_r = hwdata & P1_GATE_MASK;
      default:
        st_nxt.hs_gate_r = st_r.hs_gate_r;                // Unmapped write ignored
    endcase
    // Address phase read, presented in the following data phase
    if (rd_req)
    begin
      case (rd_sel)
        SEL_HS:
          st_nxt.hrdata_r = st_nxt.hs_gate_r;
        SEL_P2:
          st_nxt.hrdata_r = st_nxt.p2_gate_r;
        SEL_P1:
          st_nxt.hrdata_r = st_nxt.p1_gate_r;
        default:
          st_nxt.hrdata_r = 32'h0000_0000;                // Unmapped reads zero
      endcase
    end
  end

  // State register with documented reset values
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      st_r.hs_gate_r <= HS_GATE_RESET;
      st_r.p2_gate_r <= P2_GATE_RESET;
      st_r.p1_gate_r <= P1_GATE_RESET;
      st_r.hrdata_r  <= 32'h0000_0000;
    end
    else
      st_r <= st_nxt;
  end

  assign hrdata = st_r.hrdata_r;

  // Enable per gated clock
  // SRAM clock always runs while awake; the bit only matters in sleep.
  always_comb
  begin
    gate_en[0]  = st_r.hs_gate_r[POWER_DELIVERY_CLOCK_ON];
    gate_en[1]  = st_r.hs_gate_r[FULLSPEED_USB_CLOCK_ON];
    gate_en[2]  = st_r.hs_gate_r[SRAM_SLEEP_CLOCK_ON] || !sleep_mode;
    gate_en[3]  = st_r.hs_gate_r[DMA_CLOCK_ON];
    gate_en[4]  = st_r.p2_gate_r[SERIAL1_CLOCK_ON];
    gate_en[5]  = st_r.p2_gate_r[SPI_CLOCK_ON];
    gate_en[6]  = st_r.p2_gate_r[ADVANCED_TIMER_CLOCK_ON];
    gate_en[7]  = st_r.p2_gate_r[ADC_CLOCK_ON];
    gate_en[8]  = st_r.p2_gate_r[PORT_C_CLOCK_ON];
    gate_en[9]  = st_r.p2_gate_r[PORT_B_CLOCK_ON];
    gate_en[10] = st_r.p2_gate_r[PORT_A_CLOCK_ON];
    gate_en[11] = st_r.p2_gate_r[ALT_FUNCTION_CLOCK_ON];
    gate_en[12] = st_r.p1_gate_r[POWER_IF_CLOCK_ON];
    gate_en[13] = st_r.p1_gate_r[I2C_CLOCK_ON];
    gate_en[14] = st_r.p1_gate_r[SERIAL4_CLOCK_ON];
    gate_en[15] = st_r.p1_gate_r[SERIAL3_CLOCK_ON];
    gate_en[16] = st_r.p1_gate_r[SERIAL2_CLOCK_ON];
    gate_en[17] = st_r.p1_gate_r[WINDOW_WATCHDOG_CLOCK_ON];
    gate_en[18] = st_r.p1_gate_r[TIMER3_CLOCK_ON];
    gate_en[19] = st_r.p1_gate_r[TIMER2_CLOCK_ON];
  end

  // One glitch-free gate per peripheral clock
  // Half rate is the price of making each gated clock a flop output.
  for (genvar g = 0; g < GATE_COUNT; g++)
  begin : g_gate
    gclk_cell u_cell (
      .clock  (clock),
      .srst   (srst),
      .enable (gate_en[g]),
      .gclk   (gclk_vec[g])
    );
  end

  // Gated clocks to the ports
  assign power_delivery_gclk  = gclk_vec[0];
  assign fullspeed_usb_gclk   = gclk_vec[1];
  assign sram_gclk            = gclk_vec[2];
  assign dma_gclk             = gclk_vec[3];
  assign serial1_gclk         = gclk_vec[4];
  assign spi_gclk             = gclk_vec[5];
  assign advanced_timer_gclk  = gclk_vec[6];
  assign adc_gclk             = gclk_vec[7];
  assign port_c_gclk          = gclk_vec[8];
  assign port_b_gclk          = gclk_vec[9];
  assign port_a_gclk          = gclk_vec[10];
  assign alt_function_gclk    = gclk_vec[11];
  assign power_if_gclk        = gclk_vec[12];
  assign i2c_gclk             = gclk_vec[13];
  assign serial4_gclk         = gclk_vec[14];
  assign serial3_gclk         = gclk_vec[15];
  assign serial2_gclk         = gclk_vec[16];
  assign window_watchdog_gclk = gclk_vec[17];
  assign timer3_gclk          = gclk_vec[18];
  assign timer2_gclk          = gclk_vec[19];

  // Reset values seen in the first cycle after release
  AST_HS_RESET: assert property (@(posedge clock) disable iff (srst)
    $fell(srst) |-> (st_r.hs_gate_r == 32'h0002_1004))
    else $error("high-speed gate register reset value wrong");

  AST_P2_RESET: assert property (@(posedge clock) disable iff (srst)
    $fell(srst) |-> (st_r.p2_gate_r == 32'h0000_0000))
    else $error("second bus gate register reset value wrong");

  AST_P1_RESET: assert property (@(posedge clock) disable iff (srst)
    $fell(srst) |-> (st_r.p1_gate_r == 32'h0000_0000))
    else $error("first bus gate register reset value wrong");

  // DMA and USB clocks idle / running after reset
  AST_RESET_CLOCKS: assert property (@(posedge clock) disable iff (srst)
    $fell(srst) |-> !dma_gclk ##1 (!dma_gclk && fullspeed_usb_gclk && power_delivery_gclk))
    else $error("clock state after reset wrong");

  // Reserved bits never set
  AST_RSVD_ZERO: assert property (@(posedge clock) disable iff (srst)
    ((st_r.hs_gate_r & ~32'h0002_1005) == 32'h0) && ((st_r.p2_gate_r & ~32'h0000_5A1D) == 32'h0)
    && ((st_r.p1_gate_r & ~32'h102E_0803) == 32'h0))
    else $error("reserved gate bit set");

  // A write lands one edge after its data phase; its clock follows one edge later
  AST_P2_WRITE: assert property (@(posedge clock) disable iff (srst)
    (wr_sel == SEL_P2) |=> (st_r.p2_gate_r == ($past(hwdata) & 32'h0000_5A1D))
    ##1 (serial1_gclk == 1'b0 || $past(hwdata[14], 2)))
    else $error("second bus gate write not taken");

  // Watchdog clock follows its bit two edges after the write
  AST_WDG_FOLLOWS: assert property (@(posedge clock) disable iff (srst)
    ((wr_sel == SEL_P1) && !hwdata[11]) |=> ##1 !window_watchdog_gclk)
    else $error("watchdog clock not stopped");

  // Unmapped read returns zero
  AST_UNMAPPED_READ: assert property (@(posedge clock) disable iff (srst)
    (rd_req && (rd_sel == SEL_NONE)) |=> (hrdata == 32'h0000_0000))
    else $error("unmapped read not zero");

  // Sleep with SRAM bit clear stops that clock
  AST_SRAM_SLEEP: assert property (@(posedge clock) disable iff (srst)
    (sleep_mode && !st_r.hs_gate_r[SRAM_SLEEP_CLOCK_ON]) |=> !sram_gclk)
    else $error("SRAM clock ran in sleep while disabled");

  // Awake, the SRAM clock toggles whatever its bit holds
  AST_SRAM_AWAKE: assert property (@(posedge clock) disable iff (srst)
    (!sleep_mode && !srst) |=> (sram_gclk != $past(sram_gclk)))
    else $error("SRAM clock stalled while awake");

  // High-speed register write lands masked
  AST_HS_WRITE: assert property (@(posedge clock) disable iff (srst)
    (wr_sel == SEL_HS) |=> (st_r.hs_gate_r == ($past(hwdata) & HS_GATE_MASK)))
    else $error("high-speed gate write not taken");

  // First peripheral bus register write lands masked
  AST_P1_WRITE: assert property (@(posedge clock) disable iff (srst)
    (wr_sel == SEL_P1) |=> (st_r.p1_gate_r == ($past(hwdata) & P1_GATE_MASK)))
    else $error("first bus gate write not taken");

  // Read of the first bus register returns its current contents
  AST_P1_READ: assert property (@(posedge clock) disable iff (srst)
    (rd_req && (rd_sel == SEL_P1)) |=> (hrdata == st_r.p1_gate_r))
    else $error("first bus gate read data wrong");

  // DMA clock held low while its bit is clear
  AST_DMA_GATED: assert property (@(posedge clock) disable iff (srst)
    !st_r.hs_gate_r[DMA_CLOCK_ON] |=> !dma_gclk)
    else $error("DMA clock ran while disabled");

  // Port A clock held low while its bit is clear
  AST_PORT_A_GATED: assert property (@(posedge clock) disable iff (srst)
    !st_r.p2_gate_r[PORT_A_CLOCK_ON] |=> !port_a_gclk)
    else $error("port A clock ran while disabled");

  // Timer 2 clock toggles while its bit is set; reset edge excluded
  AST_TIMER2_RUNS: assert property (@(posedge clock) disable iff (srst)
    (st_r.p1_gate_r[TIMER2_CLOCK_ON] && !srst) |=> (timer2_gclk != $past(timer2_gclk)))
    else $error("timer 2 clock stalled while enabled");

  COV_WRITE_HS: cover property (@(posedge clock) disable iff (srst) wr_sel == SEL_HS);
  COV_READ_P1: cover property (@(posedge clock) disable iff (srst) rd_req && (rd_sel == SEL_P1));
  COV_DMA_RUN: cover property (@(posedge clock) disable iff (srst) $rose(dma_gclk));
  COV_SLEEP_STOP: cover property (@(posedge clock) disable iff (srst) sleep_mode && $fell(sram_gclk));

endmodule : periph_clock_gate

// file: bench/periph_clock_gate_tb.sv
// Self-checking bench for the peripheral clock gating block.
// Assumes the clock_gate_pkg package and a zero-wait AHB-Lite slave.
`timescale 1ns/1ns
module periph_clock_gate_tb
  import clock_gate_pkg::*;
;
  logic        clock      = 1'b0;  // System clock
  logic        srst       = 1'b1;  // Synchronous reset
  logic        hsel       = 1'b0;  // Bus select
  logic [31:0] haddr      = 32'h0; // Bus address
  logic [1:0]  htrans     = 2'h0;  // Transfer kind
  logic        hwrite     = 1'b0;  // Write strobe
  logic [2:0]  hsize      = 3'h2;  // Transfer size
  logic [31:0] hwdata     = 32'h0; // Write data
  logic        sleep_mode = 1'b0;  // System sleep level
  logic [31:0] hrdata;             // Read data
  logic        hreadyout;          // Slave ready
  logic        hresp;              // Slave response
  logic [19:0] gv;                 // All gated clocks
  logic [31:0] m_hs, m_p2, m_p1;   // Register model
  logic [31:0] exp_q[$];           // Expected read data
  logic        rd_dp      = 1'b0;  // Read data phase pending
  int          err_count  = 0;     // Mismatches
  int          num_checks = 0;     // Comparisons
  int          cycles     = 0;     // Timeout counter
  logic [31:0] seed_v;             // Seed call result

  // Free-running clock, 40 ns period
  always #20 clock = ~clock;

  periph_clock_gate i_dut
  (
    .clock(clock), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .sleep_mode(sleep_mode),
    .power_delivery_gclk(gv[19]), .fullspeed_usb_gclk(gv[18]), .sram_gclk(gv[17]),
    .dma_gclk(gv[16]), .serial1_gclk(gv[15]), .spi_gclk(gv[14]),
    .advanced_timer_gclk(gv[13]), .adc_gclk(gv[12]), .port_c_gclk(gv[11]),
    .port_b_gclk(gv[10]), .port_a_gclk(gv[9]), .alt_function_gclk(gv[8]),
    .power_if_gclk(gv[7]), .i2c_gclk(gv[6]), .serial4_gclk(gv[5]), .serial3_gclk(gv[4]),
    .serial2_gclk(gv[3]), .window_watchdog_gclk(gv[2]), .timer3_gclk(gv[1]),
    .timer2_gclk(gv[0])
  );

  // Verdict and end of run
  task automatic end_of_test();
    if (err_count == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_of_test

  // One comparison
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check

  // Model value of an address; unmapped places read zero
  function automatic logic [31:0] model_of(input logic [31:0] addr);
    case (addr[7:0])
      HS_GATE_OFFSET: return m_hs;
      P2_GATE_OFFSET: return m_p2;
      P1_GATE_OFFSET: return m_p1;
      default:        return 32'h0;
    endcase
  endfunction : model_of

  // Expected running set, in the order of gv
  function automatic logic [19:0] exp_run();
    return {m_hs[POWER_DELIVERY_CLOCK_ON], m_hs[FULLSPEED_USB_CLOCK_ON],
            m_hs[SRAM_SLEEP_CLOCK_ON] | ~sleep_mode, m_hs[DMA_CLOCK_ON],
            m_p2[SERIAL1_CLOCK_ON], m_p2[SPI_CLOCK_ON], m_p2[ADVANCED_TIMER_CLOCK_ON],
            m_p2[ADC_CLOCK_ON], m_p2[PORT_C_CLOCK_ON], m_p2[PORT_B_CLOCK_ON],
            m_p2[PORT_A_CLOCK_ON], m_p2[ALT_FUNCTION_CLOCK_ON],
            m_p1[POWER_IF_CLOCK_ON], m_p1[I2C_CLOCK_ON], m_p1[SERIAL4_CLOCK_ON],
            m_p1[SERIAL3_CLOCK_ON], m_p1[SERIAL2_CLOCK_ON], m_p1[WINDOW_WATCHDOG_CLOCK_ON],
            m_p1[TIMER3_CLOCK_ON], m_p1[TIMER2_CLOCK_ON]};
  endfunction : exp_run

  // Single write; model follows only word writes to mapped places
  task automatic ahb_write(input logic [31:0] addr, input logic [31:0] data, input logic [2:0] size);
    hsel   <= 1'b1;
    haddr  <= addr;
    htrans <= 2'h2;
    hwrite <= 1'b1;
    hsize  <= size;
    do @(posedge clock); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= data;
    do @(posedge clock); while (hreadyout !== 1'b1);
    if (size == HSIZE_WORD)
    begin
      case (addr[7:0])
        HS_GATE_OFFSET: m_hs = data & HS_GATE_MASK;
        P2_GATE_OFFSET: m_p2 = data & P2_GATE_MASK;
        P1_GATE_OFFSET: m_p1 = data & P1_GATE_MASK;
        default: ;
      endcase
    end
  endtask : ahb_write

  // Single read; the monitor compares the data
  task automatic ahb_read(input logic [31:0] addr);
    exp_q.push_back(model_of(addr));
    hsel   <= 1'b1;
    haddr  <= addr;
    htrans <= 2'h2;
    hwrite <= 1'b0;
    hsize  <= HSIZE_WORD;
    do @(posedge clock); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    do @(posedge clock); while (hreadyout !== 1'b1);
  endtask : ahb_read

  // Watch two low-phase samples; running must toggle, stopped must stay low
  task automatic check_clocks();
    logic [19:0] g1, g2, s, e;
    repeat (4) @(posedge clock);
    @(negedge clock);
    g1 = gv;
    @(negedge clock);
    g2 = gv;
    e = exp_run();
    s = ((g1 ^ g2) & e) | ((g1 | g2) & ~e);
    check({28'h0, s[19:16]}, {28'h0, e[19:16]});
    check({24'h0, s[15:8]}, {24'h0, e[15:8]});
    check({24'h0, s[7:0]}, {24'h0, e[7:0]});
    @(posedge clock);
  endtask : check_clocks

  // Reset for 12 cycles, model back to reset values
  task automatic do_reset();
    srst <= 1'b1;
    repeat (12) @(posedge clock);
    srst <= 1'b0;
    m_hs = HS_GATE_RESET;
    m_p2 = P2_GATE_RESET;
    m_p1 = P1_GATE_RESET;
  endtask : do_reset

  // Read all three and the clocks
  task automatic read_all();
    ahb_read({24'h0, HS_GATE_OFFSET});
    ahb_read({24'h0, P2_GATE_OFFSET});
    ahb_read({24'h0, P1_GATE_OFFSET});
    check_clocks();
  endtask : read_all

  // Monitor: each completed read data phase takes the oldest note
  always @(posedge clock)
  begin
    if (srst)
      rd_dp <= 1'b0;
    else if (hreadyout === 1'b1)
    begin
      if (rd_dp)
      begin
        check({31'h0, hresp}, {31'h0, HRESP_OKAY});
        if (exp_q.size() == 0)
        begin
          err_count++;
          $display("wrong value at %0t: read with no expectation", $time);
        end
        else
          check(hrdata, exp_q.pop_front());
      end
      rd_dp <= hsel && htrans[1] && !hwrite && (hsize == HSIZE_WORD);
    end
  end

  // Hang guard, far above the expected run length
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      err_count++;
      end_of_test();
    end
  end

  // Main sequence
  initial
  begin
    logic [31:0] a;
    seed_v = $urandom(25921);
    do_reset();
    @(posedge clock);
    read_all(); // Reset values and the clocks that run from reset
    // All ones then all zeros on each register: every enable on and off
    for (int i = 0; i < 3; i++)
    begin
      a = (i == 0) ? {24'h0, HS_GATE_OFFSET} : (i == 1) ? {24'h0, P2_GATE_OFFSET} : {24'h0, P1_GATE_OFFSET};
      ahb_write(a, 32'hFFFF_FFFF, HSIZE_WORD);
      ahb_read(a); // Straight after the write, one cycle after its data phase: stored value
      check_clocks();
    end
    for (int i = 0; i < 3; i++)
    begin
      a = (i == 0) ? {24'h0, HS_GATE_OFFSET} : (i == 1) ? {24'h0, P2_GATE_OFFSET} : {24'h0, P1_GATE_OFFSET};
      ahb_write(a, 32'h0, HSIZE_WORD);
      ahb_read(a);
      check_clocks();
    end
    // Sleep with the SRAM bit clear, then set
    sleep_mode <= 1'b1;
    check_clocks();
    ahb_write({24'h0, HS_GATE_OFFSET}, 32'h0000_0004, HSIZE_WORD);
    check_clocks();
    sleep_mode <= 1'b0;
    // Random contents and sleep levels
    for (int i = 0; i < 12; i++)
    begin
      a = (i % 3 == 0) ? {24'h0, HS_GATE_OFFSET} : (i % 3 == 1) ? {24'h0, P2_GATE_OFFSET} : {24'h0, P1_GATE_OFFSET};
      ahb_write(a, $urandom(), HSIZE_WORD);
      sleep_mode <= 1'($urandom_range(0, 1));
      ahb_read(a);
      check_clocks();
    end
    sleep_mode <= 1'b0;
    // Unmapped places and a halfword write change nothing
    ahb_write(32'h0000_0020, 32'hFFFF_FFFF, HSIZE_WORD);
    ahb_read(32'h0000_0020);
    ahb_write(32'h0000_0010, 32'hFFFF_FFFF, HSIZE_WORD);
    ahb_read(32'h0000_0010);
    ahb_write({24'h0, P2_GATE_OFFSET}, 32'hFFFF_FFFF, 3'h1);
    read_all();
    // Second reset in mid-run with every first bus enable set and only DMA on the high-speed bus
    ahb_write({24'h0, P1_GATE_OFFSET}, 32'hFFFF_FFFF, HSIZE_WORD);
    ahb_write({24'h0, HS_GATE_OFFSET}, 32'h0000_0001, HSIZE_WORD);
    do_reset();
    @(posedge clock);
    read_all();
    repeat (2) @(posedge clock);
    check(32'(exp_q.size()), 32'h0);
    end_of_test();
  end

endmodule : periph_clock_gate_tb
